// file: core/pixel_lane_map.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================================
// Colour mapper for one serialized pixel
// ============================================================================
module pixel_lane_map
(
  input  wire pixmap_pkg::pix_t  pix,
  input  wire pixmap_pkg::mode_t mode,
  input  wire logic [7:0]        pixel_mask,
  output var  pixmap_pkg::map_t  mapped
);

  logic [7:0] r;
  logic [7:0] g;
  logic [7:0] b;

  assign r = pix.red_pixel_inputs;
  assign g = pix.green_pixel_inputs;
  assign b = pix.blue_pixel_inputs;

  // Per-mode address or direct DAC layout; unused inputs simply dropped
  always_comb
  begin
    mapped = '0;
    unique case (mode)
      pixmap_pkg::M_PSEUDO_R: mapped.addr = {3{r & pixel_mask}}; // see [RULE9]
      pixmap_pkg::M_PSEUDO_G: mapped.addr = {3{g & pixel_mask}}; // see [RULE4]
      pixmap_pkg::M_PSEUDO_B: mapped.addr = {3{b & pixel_mask}};
      pixmap_pkg::M_TRUE24:   mapped.addr = {r, g, b};  // see [RULE5] [RULE23]
      pixmap_pkg::M_TRUE16:                             // see [RULE1] [RULE6]
        mapped.addr = {{3'h0, r[7:3]}, {2'h0, r[2:0], g[7:5]},
                       {3'h0, g[4:0]}};
      pixmap_pkg::M_TRUE15A:                            // see [RULE3] [RULE7]
        mapped.addr = {{3'h0, r[7:3]}, {3'h0, g[7:3]}, {3'h0, b[7:3]}};
      pixmap_pkg::M_TRUE15B:                            // see [RULE8]
        mapped.addr = {{3'h0, r[6:2]}, {3'h0, r[1:0], g[7:5]},
                       {3'h0, g[4:0]}};
      pixmap_pkg::M_BYP24:
      begin
        mapped.bypass = 1'b1;
        mapped.byp    = {{r, 2'h0}, {g, 2'h0}, {b, 2'h0}}; // see [RULE10]
      end
      pixmap_pkg::M_BYP16:
      begin
        mapped.bypass = 1'b1;
        mapped.byp    = {{r[7:3], 5'h00}, {r[2:0], g[7:5], 4'h0},
                         {g[4:0], 5'h00}};                  // see [RULE12]
      end
      pixmap_pkg::M_BYP15:
      begin
        mapped.bypass = 1'b1;
        mapped.byp    = {{r[6:2], 5'h00}, {r[1:0], g[7:5], 5'h00},
                         {g[4:0], 5'h00}};                  // see [RULE13]
      end
      default: mapped = '0;
    endcase
  end

endmodule // pixel_lane_map
`default_nettype wire

// file: core/pixel_port_mux_color_mapper.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// [RULE1] Code 1011: 16-bit pixels, 5/6/5 table bits, 64 entries used.
// [RULE2] Resolution one: 10 bits per colour; zero: 8 bits per colour.
// [RULE3] Codes 1100 and 1101: 15-bit pixels, 5 bits per colour, 32 entries.
// [RULE4] Codes 0000, 0100, 1000: 8-bit pixel indexes 256 entries.
// [RULE5] 24-bit true colour takes red, green, blue bytes directly.
// [RULE6] 16-bit mode uses red and green ports only, entries 0 to 63.
// [RULE7] First 15-bit mode uses upper five bits of each port.
// [RULE8] Second 15-bit mode uses red 6..0 and green 7..0, entries 0-31.
// [RULE9] Pseudo colour has three sub-modes, one per input port.
// [RULE10] 24-bit bypass skips mask and table, bytes on top DAC bits.
// [RULE11] Bypass chosen by colour-mode field or per pixel by select inputs.
// [RULE12] 16-bit bypass fills 5/6/5 top DAC bits, rest zero.
// [RULE13] 15-bit bypass fills top five bits of each DAC, rest zero.
// [RULE14] 4:1 outputs latched A, B, C, D one per clock, repeating.
// [RULE15] 2:1 outputs only A and B alternately.
// [RULE16] Control pair one,zero forces pseudo colour, latch clock at 1/8.
// [RULE17] 8:1 order GA RA GB RB GC RC GD RD, through the mask.
// [RULE18] 8:1 blue inputs become extra selects, 2 bits per pixel.
// [RULE19] Blank, sync, parity, tri-level sync held to multiplex boundary.
// [RULE20] All pixel-port inputs captured together on strobe rising edge.
// [RULE21] Outside party supplies strobe, typically from latch clock output.
// [RULE22] Bus width and resolution choose 10-bit, 8+2 or 8-bit transfers.
// [RULE23] Code 1110: 24-bit true colour mapped through the table.
// [RULE24] Resolution zero forces two low DAC bits to zero.
// [RULE25] Reset or writing 1, 0, 1 to sequence bit restarts at A.
// [RULE26] Reserved colour codes keep the previous valid mode.
module pixel_port_mux_color_mapper
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output var  logic              hreadyout,
  output var  logic              hresp,
  output var  logic [31:0]       hrdata,
  input  wire logic              pixel_latch_strobe,
  input  wire pixmap_pkg::pins_t pixel_pins,
  output var  logic              latch_clock_output,
  output var  pixmap_pkg::dac_t  dac_data,
  output var  pixmap_pkg::ctl_t  video_ctl_out,
  output var  logic [1:0]        palette_select_out
);

  // ========================================
  // Bus slave: zero wait states, writes land in the data phase
  // ========================================
  logic                  wr_pend;
  logic [7:0]            wr_addr;
  logic [31:0]           rd_value;
  wire                   addr_phase = hsel & hready & htrans[1];

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase capture; hsize ignored, word transfers only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend <= addr_phase & hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Read data flopped at the address phase for the following data phase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hrdata <= 32'h0000_0000;
    else if (addr_phase & ~hwrite)
      hrdata <= rd_value;
  end

  wire wr_mode     = wr_pend & (wr_addr == pixmap_pkg::OFS_MODE);
  wire wr_color    = wr_pend & (wr_addr == pixmap_pkg::OFS_COLOR);
  wire wr_mux      = wr_pend & (wr_addr == pixmap_pkg::OFS_MUX);
  wire wr_mask     = wr_pend & (wr_addr == pixmap_pkg::OFS_MASK);
  wire wr_pal_addr = wr_pend & (wr_addr == pixmap_pkg::OFS_PAL_ADDR);
  wire wr_pal_data = wr_pend & (wr_addr == pixmap_pkg::OFS_PAL_DATA);

  // ========================================
  // Control registers
  // ========================================
  logic [2:0]        mode_reg;
  logic [3:0]        color_mode_field;
  logic [2:0]        mux_ctl;
  logic [7:0]        pixel_mask;
  pixmap_pkg::mode_t eff_mode;

  wire dac_resolution_select = mode_reg[pixmap_pkg::MODE_RES_BIT];
  wire bus_width_ten         = mode_reg[pixmap_pkg::MODE_BUS10_BIT];
  wire mux_eight_ctl_hi      = mux_ctl[pixmap_pkg::MUX_HI_BIT];
  wire mux_eight_ctl_lo      = mux_ctl[pixmap_pkg::MUX_LO_BIT];
  wire ps_bypass_enable      = mux_ctl[pixmap_pkg::MUX_PSBYP_BIT];
  wire mux_eight             = mux_eight_ctl_hi & ~mux_eight_ctl_lo;
  wire mux_two               = ~mux_eight_ctl_hi & mux_eight_ctl_lo;

  // Power-on values all ones except the mux bypass-enable bit, as the part comes up
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_reg         <= pixmap_pkg::MODE_RST;
      color_mode_field <= pixmap_pkg::COLOR_RST;
      mux_ctl          <= pixmap_pkg::MUX_RST;
      pixel_mask       <= pixmap_pkg::MASK_RST;
    end
    else
    begin
      if (wr_mode)
        mode_reg <= hwdata[2:0];
      if (wr_color)
        color_mode_field <= hwdata[3:0];
      if (wr_mux)
        mux_ctl <= hwdata[2:0];
      if (wr_mask)
        pixel_mask <= hwdata[7:0];
    end
  end

  // Effective mode follows only valid codes; reset code is reserved
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      eff_mode <= pixmap_pkg::M_PSEUDO_R;
    else if (pixmap_pkg::code_valid(color_mode_field))
      eff_mode <= pixmap_pkg::code_to_mode(color_mode_field); // see [RULE26]
  end

  // ========================================
  // Sequence-reset detector: 1, 0, 1 written to the sequence bit
  // ========================================
  pixmap_pkg::seq_t seq_state;
  pixmap_pkg::seq_t next_seq_state;
  wire              seq_val  = hwdata[pixmap_pkg::MODE_SEQ_BIT];
  wire              seq_fire = wr_mode & seq_val &
                               (seq_state == pixmap_pkg::SQ_WAIT_LAST);

  always_comb
  begin
    next_seq_state = seq_state;
    if (wr_mode)
    begin
      unique case (seq_state)
        pixmap_pkg::SQ_WAIT_ONE:
          if (seq_val)
            next_seq_state = pixmap_pkg::SQ_WAIT_ZERO;
        pixmap_pkg::SQ_WAIT_ZERO:
          if (!seq_val)
            next_seq_state = pixmap_pkg::SQ_WAIT_LAST;
        pixmap_pkg::SQ_WAIT_LAST:
          if (seq_val)
            next_seq_state = pixmap_pkg::SQ_WAIT_ZERO; // Final one may lead
        default:
          next_seq_state = pixmap_pkg::SQ_WAIT_ONE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      seq_state <= pixmap_pkg::SQ_WAIT_ONE;
    else
      seq_state <= next_seq_state;
  end

  // ========================================
  // Palette port: colour components assembled per bus width
  // ========================================
  pixmap_pkg::dac_t lut [256];
  logic [7:0]       pal_addr;
  logic [1:0]       pal_ptr;
  logic             pal_half;
  logic [7:0]       pal_hi8;
  logic [9:0]       pal_red;
  logic [9:0]       pal_green;

  wire       pal_full  = bus_width_ten & dac_resolution_select;
  wire       pal_split = ~bus_width_ten & dac_resolution_select;
  wire       pal_first = pal_split & ~pal_half;
  wire       pal_done  = wr_pal_data & ~pal_first;
  wire       pal_blue  = pal_done & (pal_ptr == 2'd2);
  // Byte pair arrives high eight first, then the two low bits
  wire [9:0] pal_comp  = pal_full  ? hwdata[9:0] :             // see [RULE22]
                         pal_split ? {pal_hi8, hwdata[1:0]} :
                                     {hwdata[7:0], 2'h0};

  // Writing the address restarts at red and drops any half byte pair
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pal_addr  <= 8'h00;
      pal_ptr   <= 2'd0;
      pal_half  <= 1'b0;
      pal_hi8   <= 8'h00;
      pal_red   <= 10'h000;
      pal_green <= 10'h000;
    end
    else if (wr_pal_addr)
    begin
      pal_addr <= hwdata[7:0];
      pal_ptr  <= 2'd0;
      pal_half <= 1'b0;
    end
    else if (wr_pal_data)
    begin
      pal_half <= pal_first;
      if (pal_first)
        pal_hi8 <= hwdata[7:0];
      if (pal_done && pal_ptr == 2'd0)
        pal_red <= pal_comp;
      if (pal_done && pal_ptr == 2'd1)
        pal_green <= pal_comp;
      if (pal_done)
        pal_ptr <= pal_blue ? 2'd0 : pal_ptr + 2'd1;
      if (pal_blue)
        pal_addr <= pal_addr + 8'h01;
    end
  end

  // Table storage, 30 bits wide; 8-bit entries live in the top bits
  always_ff @(posedge clk)
  begin
    if (pal_blue)
      lut[pal_addr] <= '{pal_red, pal_green, pal_comp}; // see [RULE2]
  end

  // ========================================
  // Pixel port crossing: strobe and pins through two flops
  // ========================================
  logic              strobe_s1;
  logic              strobe_s2;
  logic              strobe_prev;
  pixmap_pkg::pins_t pins_s1;
  pixmap_pkg::pins_t pins_s2;
  pixmap_pkg::pins_t latched;
  pixmap_pkg::pins_t shadow;

  // Data and strobe share the same delay, so setup is preserved
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strobe_s1   <= 1'b0;
      strobe_s2   <= 1'b0;
      strobe_prev <= 1'b0;
      pins_s1     <= '0;
      pins_s2     <= '0;
    end
    else
    begin
      strobe_s1   <= pixel_latch_strobe;
      strobe_s2   <= strobe_s1;
      strobe_prev <= strobe_s2;
      pins_s1     <= pixel_pins;
      pins_s2     <= pins_s1;
    end
  end

  wire strobe_rise = strobe_s2 & ~strobe_prev;

  // ========================================
  // Serializer index, latch clock divider and shadow load
  // ========================================
  logic [2:0] idx;
  logic [2:0] next_idx;
  wire  [2:0] idx_last = mux_eight ? 3'd7 : (mux_two ? 3'd1 : 3'd3);
  wire  [2:0] idx_half = mux_eight ? 3'd4 : (mux_two ? 3'd1 : 3'd2);
  wire        idx_wrap = (idx >= idx_last);

  // Restart at A on reset or on the 1,0,1 sequence
  assign next_idx = (seq_fire | idx_wrap) ? 3'd0 : idx + 3'd1; // see [RULE25]

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      idx                <= 3'd0;
      latch_clock_output <= 1'b1;
    end
    else
    begin
      idx                <= next_idx;
      latch_clock_output <= (next_idx < idx_half); // see [RULE16]
    end
  end

  // All inputs caught together; shadow swaps only on the group boundary
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      latched <= '0;
      shadow  <= '0;
    end
    else
    begin
      if (strobe_rise)
        latched <= pins_s2;                          // see [RULE20] [RULE21]
      if (idx_wrap | seq_fire)
        shadow <= latched;                           // see [RULE19]
    end
  end

  // ========================================
  // Pixel selection and mode per pixel
  // ========================================
  wire [1:0] bank_sel = mux_eight ? idx[2:1] :
                        mux_two   ? {1'b0, idx[0]} :     // see [RULE15]
                                    idx[1:0];            // see [RULE14]
  pixmap_pkg::pix_t  cur_bank;
  pixmap_pkg::pix_t  ser_pix;
  pixmap_pkg::mode_t pix_mode;
  pixmap_pkg::map_t  mapped;
  wire [7:0] eight_byte = idx[0] ? cur_bank.red_pixel_inputs
                                 : cur_bank.green_pixel_inputs; // see [RULE17]
  wire [1:0] eight_ps   = idx[0] ? cur_bank.blue_pixel_inputs[3:2]
                                 : cur_bank.blue_pixel_inputs[1:0];

  assign cur_bank = shadow.bank[bank_sel];
  // In 8:1 one byte feeds every channel and blue becomes selects
  assign ser_pix  = mux_eight ? {eight_byte, eight_byte, eight_byte,
                                 eight_ps}                 // see [RULE18]
                              : cur_bank;
  assign pix_mode = mux_eight ? pixmap_pkg::M_PSEUDO_R :   // see [RULE16]
                    (ps_bypass_enable & ser_pix.palette_select_inputs[1])
                              ? pixmap_pkg::M_BYP24 :      // see [RULE11]
                                eff_mode;

  pixel_lane_map u_map
  (
    .pix        (ser_pix),
    .mode       (pix_mode),
    .pixel_mask (pixel_mask),
    .mapped     (mapped)
  );

  // ========================================
  // Output pipeline: mapped stage, then table read and DAC format
  // ========================================
  pixmap_pkg::map_t map_q;
  pixmap_pkg::ctl_t ctl_q;
  logic [1:0]       ps_q;
  logic [2:0][9:0]  ch_raw;
  logic [2:0][9:0]  ch_out;

  assign ch_raw[2] = map_q.bypass ? map_q.byp[2] : lut[map_q.addr[2]].red;
  assign ch_raw[1] = map_q.bypass ? map_q.byp[1] : lut[map_q.addr[1]].green;
  assign ch_raw[0] = map_q.bypass ? map_q.byp[0] : lut[map_q.addr[0]].blue;

  // Low two DAC bits forced off in 8-bit resolution
  for (genvar c = 0; c < 3; c++)
  begin : g_chan
    assign ch_out[c] = dac_resolution_select ? ch_raw[c]
                     : {ch_raw[c][9:2], 2'h0};         // see [RULE24]
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      map_q              <= '0;
      ctl_q              <= '0;
      ps_q               <= 2'h0;
      dac_data           <= '0;
      video_ctl_out      <= '0;
      palette_select_out <= 2'h0;
    end
    else
    begin
      map_q              <= mapped;
      ctl_q              <= shadow.ctl;
      ps_q               <= ser_pix.palette_select_inputs;
      dac_data           <= '{ch_out[2], ch_out[1], ch_out[0]};
      video_ctl_out      <= ctl_q;
      palette_select_out <= ps_q;
    end
  end

  // ========================================
  // Read decode; unmapped offsets read zero
  // ========================================
  wire [31:0] rd_mode   = {29'h0, mode_reg};
  wire [31:0] rd_color  = {20'h0, eff_mode, 4'h0, color_mode_field};
  wire [31:0] rd_mux    = {29'h0, mux_ctl};
  wire [31:0] rd_mask   = {24'h0, pixel_mask};
  wire [31:0] rd_paddr  = {21'h0, pal_half, pal_ptr, pal_addr};
  wire [31:0] rd_pdata  = {2'h0, lut[pal_addr]};
  wire [31:0] rd_status = {28'h0, latch_clock_output, idx};

  assign rd_value = (haddr[7:0] == pixmap_pkg::OFS_MODE)     ? rd_mode   :
                    (haddr[7:0] == pixmap_pkg::OFS_COLOR)    ? rd_color  :
                    (haddr[7:0] == pixmap_pkg::OFS_MUX)      ? rd_mux    :
                    (haddr[7:0] == pixmap_pkg::OFS_MASK)     ? rd_mask   :
                    (haddr[7:0] == pixmap_pkg::OFS_PAL_ADDR) ? rd_paddr  :
                    (haddr[7:0] == pixmap_pkg::OFS_PAL_DATA) ? rd_pdata  :
                    (haddr[7:0] == pixmap_pkg::OFS_STATUS)   ? rd_status :
                                                               32'h0000_0000;

endmodule // pixel_port_mux_color_mapper
`default_nettype wire

// file: shared/pixmap_pkg.sv
package pixmap_pkg;

  // ==========================================================================
  // Register offsets (byte addresses, one aligned word each)
  // ==========================================================================
  localparam logic [7:0] OFS_MODE     = 8'h00;
  localparam logic [7:0] OFS_COLOR    = 8'h04;
  localparam logic [7:0] OFS_MUX      = 8'h08;
  localparam logic [7:0] OFS_MASK     = 8'h0C;
  localparam logic [7:0] OFS_PAL_ADDR = 8'h10;
  localparam logic [7:0] OFS_PAL_DATA = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int MODE_SEQ_BIT   = 0;
  localparam int MODE_RES_BIT   = 1;
  localparam int MODE_BUS10_BIT = 2;
  localparam int MUX_LO_BIT     = 0;
  localparam int MUX_HI_BIT     = 1;
  localparam int MUX_PSBYP_BIT  = 2;
  localparam int COLOR_EFF_POS  = 8;
  localparam logic [2:0] MODE_RST  = 3'h7;
  localparam logic [3:0] COLOR_RST = 4'hF;
  localparam logic [2:0] MUX_RST   = 3'h3;
  localparam logic [7:0] MASK_RST  = 8'hFF;

  // ==========================================================================
  // Colour-mode field codes
  // ==========================================================================
  localparam logic [3:0] CODE_PSEUDO_R = 4'h0;
  localparam logic [3:0] CODE_PSEUDO_G = 4'h4;
  localparam logic [3:0] CODE_PSEUDO_B = 4'h8;
  localparam logic [3:0] CODE_TRUE24   = 4'hE;
  localparam logic [3:0] CODE_TRUE16   = 4'hB;
  localparam logic [3:0] CODE_TRUE15A  = 4'hC;
  localparam logic [3:0] CODE_TRUE15B  = 4'hD;
  localparam logic [3:0] CODE_BYP24    = 4'h1;
  localparam logic [3:0] CODE_BYP16    = 4'h2;
  localparam logic [3:0] CODE_BYP15    = 4'h3;

  typedef enum logic [3:0] {
    M_PSEUDO_R = 4'h0, M_PSEUDO_G = 4'h1, M_PSEUDO_B = 4'h2,
    M_TRUE24   = 4'h3, M_TRUE16   = 4'h4, M_TRUE15A  = 4'h5,
    M_TRUE15B  = 4'h6, M_BYP24    = 4'h7, M_BYP16    = 4'h8,
    M_BYP15    = 4'h9
  } mode_t;

  typedef enum logic [1:0] {
    SQ_WAIT_ONE  = 2'b00,
    SQ_WAIT_ZERO = 2'b01,
    SQ_WAIT_LAST = 2'b10
  } seq_t;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [7:0] red_pixel_inputs;
    logic [7:0] green_pixel_inputs;
    logic [7:0] blue_pixel_inputs;
    logic [1:0] palette_select_inputs;
  } pix_t;

  typedef struct packed {
    logic blank_n;
    logic sync_n;
    logic field_parity;
    logic tri_level_sync;
  } ctl_t;

  // Bank 0 is pixel A, bank 3 is pixel D
  typedef struct packed {
    pix_t [3:0] bank;
    ctl_t       ctl;
  } pins_t;

  typedef struct packed {
    logic [9:0] red;
    logic [9:0] green;
    logic [9:0] blue;
  } dac_t;

  // Channel index 2 red, 1 green, 0 blue
  typedef struct packed {
    logic [2:0][7:0] addr;
    logic [2:0][9:0] byp;
    logic            bypass;
  } map_t;

  // Reserved codes report invalid so the last good mode is kept
  function automatic logic code_valid(input logic [3:0] code);
    return code inside {CODE_PSEUDO_R, CODE_PSEUDO_G, CODE_PSEUDO_B,
                        CODE_TRUE24, CODE_TRUE16, CODE_TRUE15A,
                        CODE_TRUE15B, CODE_BYP24, CODE_BYP16, CODE_BYP15};
  endfunction

  function automatic mode_t code_to_mode(input logic [3:0] code);
    mode_t m;
    m = M_PSEUDO_R;
    case (code)
      CODE_PSEUDO_G: m = M_PSEUDO_G;
      CODE_PSEUDO_B: m = M_PSEUDO_B;
      CODE_TRUE24:   m = M_TRUE24;
      CODE_TRUE16:   m = M_TRUE16;
      CODE_TRUE15A:  m = M_TRUE15A;
      CODE_TRUE15B:  m = M_TRUE15B;
      CODE_BYP24:    m = M_BYP24;
      CODE_BYP16:    m = M_BYP16;
      CODE_BYP15:    m = M_BYP15;
      default:       m = M_PSEUDO_R;
    endcase
    return m;
  endfunction

endpackage

// file: verif/pixel_port_mux_color_mapper_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ======================================================
// Bench: bus tasks, pixel scenarios, queued expectations
module pixel_port_mux_color_mapper_tb_top;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              hsel = 1'b0;
  logic              hwrite = 1'b0;
  logic [1:0]        htrans = 2'b00;
  logic [31:0]       haddr = '0;
  logic [31:0]       hwdata = '0;
  logic              hready, hresp, lco, strobe;
  logic [31:0]       hrdata;
  logic [1:0]        psel;
  pixmap_pkg::pins_t pins, nxt = '0;
  pixmap_pkg::dac_t  dac;
  pixmap_pkg::ctl_t  ctl;
  logic [31:0]       qr[$], qd[$];
  int                n_fail = 0, n_tests = 0, seed = 4888, cyc = 0;
  pixel_port_mux_color_mapper uut (.clk, .rst, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp,
    .hrdata, .pixel_latch_strobe(strobe), .pixel_pins(pins),
    .latch_clock_output(lco), .dac_data(dac), .video_ctl_out(ctl),
    .palette_select_out(psel));
  pixel_source src (.next_pins(nxt), .pixel_latch_strobe(strobe),
    .pixel_pins(pins));
  initial forever #50 clk = ~clk;
  // Hang guard, far above the expected run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000) begin n_fail++; tally_and_finish(); end
  end
  task automatic cmp(string what, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (e !== g) begin n_fail++; $display("Error %s exp %h got %h", what, e, g); end
  endtask
  // Single AHB transfer: address phase, then data phase
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    {hsel, htrans, hwrite, haddr} <= {3'b110, w, 24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    {hsel, htrans} <= 3'b000;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
  endtask
  // Bypass pictures of one pixel on the three DAC inputs
  function automatic logic [29:0] want(logic [3:0] c, pixmap_pkg::pix_t p);
    logic [7:0] r, g;
    r = p.red_pixel_inputs;
    g = p.green_pixel_inputs;
    case (c)
      pixmap_pkg::CODE_BYP16: return {r[7:3], 5'h0, r[2:0], g[7:5], 4'h0, g[4:0], 5'h0};
      pixmap_pkg::CODE_BYP15: return {r[6:2], 5'h0, r[1:0], g[7:5], 5'h0, g[4:0], 5'h0};
      default: return {r, 2'h0, g, 2'h0, p.blue_pixel_inputs, 2'h0};
    endcase
  endfunction
  // Wait, bounded, for a pixel; return just after the next one launches
  task automatic settle(logic [29:0] e);
    repeat (24) @(posedge clk);
    repeat (40) begin @(negedge clk); if (dac === e) break; end
    @(posedge clk);
  endtask
  // Oldest note meets the output it describes
  always @(negedge clk)
  begin
    if (qr.size() > 0) cmp("hrdata", qr.pop_front(), hrdata);
    if (qd.size() > 0) cmp("psel,dac", qd.pop_front(), {psel, dac});
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, pixmap_pkg::OFS_COLOR, 0); qr.push_back(32'hF);
    bus(1'b0, pixmap_pkg::OFS_MUX, 0); qr.push_back(32'h3);
    bus(1'b0, 8'h40, 0); qr.push_back(32'h0);
    $display("test registers done");
    bus(1'b1, pixmap_pkg::OFS_COLOR, 32'h1);
    nxt = 108'({$random(seed), $random(seed), $random(seed), $random(seed)});
    for (int m = 3; m > 0; m -= 2)
    begin
      if (m == 1) bus(1'b1, pixmap_pkg::OFS_MUX, 32'h1);
      settle(want(4'h1, nxt.bank[0]));
      for (int i = 1; i < 5; i++) qd.push_back({nxt.bank[i & m].palette_select_inputs,
        want(4'h1, nxt.bank[i & m])});
      wait (qd.size() == 0);
      $display("test order done");
    end
    for (int i = 1; i < 4; i++) nxt.bank[i] = nxt.bank[0];
    for (int c = 2; c < 4; c++)
    begin
      bus(1'b1, pixmap_pkg::OFS_COLOR, c);
      settle(want(4'(c), nxt.bank[0]));
      qd.push_back({nxt.bank[0].palette_select_inputs,
        want(4'(c), nxt.bank[0])});
    end
    bus(1'b1, pixmap_pkg::OFS_PAL_ADDR, 32'h0);
    for (int i = 0; i < 6; i++) bus(1'b1, pixmap_pkg::OFS_PAL_DATA, i * 7 + 1);
    nxt.bank = '0;
    for (int i = 0; i < 4; i++) nxt.bank[i].red_pixel_inputs = 8'h01;
    bus(1'b1, pixmap_pkg::OFS_MUX, 32'h2);
    settle({10'd1, 10'd8, 10'd15});
    for (int i = 0; i < 3; i++) qd.push_back(i[0] ? {10'd1, 10'd8, 10'd15} : {10'd22, 10'd29, 10'd36});
    wait (qd.size() == 0);
    $display("test eight to one done");
    tally_and_finish();
  end
endmodule // pixel_port_mux_color_mapper_tb_top
bind pixel_port_mux_color_mapper pixmap_asserts chk (.clk, .rst, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .latch_clock_output, .video_ctl_out);
`default_nettype wire

// file: verif/pixel_source.sv
`timescale 1ns/1ns
`default_nettype none
// ======================================================
// Frame buffer side: free-running strobe, pins per group
module pixel_source
(
  input  wire pixmap_pkg::pins_t next_pins,
  output var  logic              pixel_latch_strobe,
  output var  pixmap_pkg::pins_t pixel_pins
);
  // Strobe at an eighth of the pixel rate, phase unrelated to clk
  initial
  begin
    pixel_latch_strobe = 1'b0;
    pixel_pins = '0;
    #37;
    forever #400 pixel_latch_strobe = ~pixel_latch_strobe;
  end
  // Change pins after a strobe so they hold through the next capture
  always @(negedge pixel_latch_strobe)
    pixel_pins <= next_pins;
endmodule // pixel_source
`default_nettype wire

// file: verif/pixmap_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ======================================================
// Port checks: bus answer, latch clock, control hold
module pixmap_asserts
(
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [31:0]      hrdata,
  input wire logic             latch_clock_output,
  input wire pixmap_pkg::ctl_t video_ctl_out
);
  // Accepted address phases
  wire logic take = hsel && hready && htrans[1];
  wire logic rd_take = take && !hwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ready_high_a: assert property (hreadyout)
    else $error("wait state");
  resp_okay_a: assert property (!hresp)
    else $error("error response");
  // Eight cycles covers a ratio change in mid-group
  lco_high_a: assert property ($rose(latch_clock_output) |->
    ##[1:8] $fell(latch_clock_output)) else $error("latch clock high");
  lco_low_a: assert property ($fell(latch_clock_output) |->
    ##[1:8] $rose(latch_clock_output)) else $error("latch clock low");
  read_hold_a: assert property (
    !$stable(hrdata) |-> $past(rd_take)) else $error("read data moved");
  write_keep_a: assert property (
    take && hwrite |=> $stable(hrdata)) else $error("write moved data");
  unmapped_zero_a: assert property (
    rd_take && haddr == 32'h40 |=> hrdata == 32'h0)
    else $error("unmapped read");
  ctl_hold_a: assert property (
    !$stable(video_ctl_out) |=> $stable(video_ctl_out))
    else $error("control moved in group");
endmodule // pixmap_asserts
`default_nettype wire
